//--- core/cic_pkg.sv
// Constants, offsets and field layouts of the codec configuration register block
package cic_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (printed offsets, used directly as the 7-bit address)
  // ---------------------------------------------------------------------------
  localparam logic [6:0] OFS_SAMPLE_RATE = 7'h40;
  localparam logic [6:0] OFS_LEVEL_CTRL = 7'h46;
  localparam logic [6:0] OFS_PIN_DIR = 7'h4c;
  localparam logic [6:0] OFS_PIN_POLARITY = 7'h4e;
  localparam logic [6:0] OFS_PIN_STICKY = 7'h50;
  localparam logic [6:0] OFS_PIN_WAKE_EN = 7'h52;
  localparam logic [6:0] OFS_PIN_STATUS = 7'h54;
  localparam logic [6:0] OFS_PIN_PULLUP = 7'h56;
  localparam logic [6:0] OFS_PIN_OPEN_DRAIN = 7'h58;
  localparam logic [6:0] OFS_CONFIG_ONE = 7'h5c;
  localparam logic [6:0] OFS_CONFIG_TWO = 7'h5e;
  localparam logic [6:0] OFS_PIN_INIT_STATE = 7'h60;
  localparam logic [6:0] OFS_CLK_PIN_CTRL = 7'h64;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CFG1_BANK_LSB = 13;
  localparam int CFG1_RESET_PWR_MODE = 12;
  localparam int CFG1_XTAL_LSB = 10;
  localparam int CFG1_ANALOG_SEL = 9;
  localparam int CFG1_ADC_CAL = 8;
  localparam int CFG1_CLKOUT_RUN = 7;
  localparam int CFG1_CLKOUT_IN_RESET = 6;
  localparam int CFG2_WAKE_PIN = 14;
  localparam int CFG2_MON_PIN = 13;
  localparam int CFG2_MIC_PIN = 12;
  localparam int CFG2_LINK_CHAIN = 11;
  localparam int CFG2_LINK_BYPASS = 10;
  localparam int CFG2_LINK_SLOT = 9;
  localparam int CFG2_PORT_ISOLATE = 8;
  localparam int CFG2_LINK_DELAY_LSB = 6;
  localparam int CLKCTL_OSC_LP = 3;
  localparam int CLKCTL_DRIVE_LSB = 0;

  // Pins that carry an alternate role, and the pins that strap the link mode
  localparam int PIN_MIC = 1;
  localparam int PIN_MODE_LSB = 2;
  localparam int PIN_WAKE = 3;
  localparam int PIN_MON = 4;

  // ---------------------------------------------------------------------------
  // Writable masks and values after reset
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CFG1_MASK = 16'h7f40;
  localparam logic [15:0] CFG2_MASK = 16'h7fc0;
  localparam logic [15:0] CLKCTL_MASK = 16'h000f;
  localparam logic [15:0] CFG1_RST = 16'h0000;
  localparam logic [15:0] CFG2_RST = 16'h0000;
  localparam logic [15:0] CLKCTL_RST = 16'h0007;
  localparam logic [15:0] SAMPLE_RATE_RST = 16'h0000;
  localparam logic [15:0] LEVEL_CTRL_RST = 16'h0000;
  localparam logic [1:0] BANK_ONE = 2'h1;
  localparam logic [1:0] XTAL_ID_RST = 2'h0;
  localparam logic [2:0] DRIVE_OFF = 3'h0;
  localparam logic [1:0] MODE_DSP = 2'h0;

endpackage : cic_pkg

//--- core/cic_top.sv
// Configuration registers, clock-output control and pin logic of the modem codec
// How it works
// RULE_01: Host sets bank selector to 01 before touching banked registers.
// RULE_02: Reset power mode 0 powers device fully down while reset is held.
// RULE_03: Crystal id field tells input frequency; host reprograms for non-default clock.
// RULE_04: Analog codec select, default 0, may change at any moment.
// RULE_05: Run-time clock-out enable returns to 1 at every reset release.
// RULE_06: In-reset clock-out enable keeps clock running in reset, gated by power mode.
// RULE_07: Oscillator low-power bit only reduces crystal drive.
// RULE_08: Three-bit field selects clock output driver strength.
// RULE_09: Strength 000 floats the pad, 111 full drive is default.
// RULE_10: Wake select turns pin 3 into an event flag driven high.
// RULE_11: Monitor select routes the monitor bit stream onto pin 4.
// RULE_12: Mic select turns pin 1 from input flag into analog mic input.
// RULE_13: Link chain, bypass, slot and delay act only in link mode.
// RULE_14: Pin levels are captured once, at first reset release after power.
// RULE_15: Captured pins 2 and 3 choose the serial interface mode.
// RULE_16: After power-up all pins are inputs with pull-ups on.
// RULE_17: Each pin may be event source or open-drain or push-pull output.
// RULE_18: Pin control registers keep contents through reset, cleared only by power-up.
// RULE_19: Host programs pin control registers in recommended order, wake enable last.
// RULE_20: Sample rate and level registers accept writes at any time; the code drops them while device reset is held.
// RULE_21: Banked offsets reach the register of the currently selected bank.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module cic_top
  import cic_pkg::*;
#(
  parameter int NUM_PINS = 8
) (
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic POR_N_IN,
  input wire logic [6:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [15:0] REG_RDATA_OUT,
  input wire logic [NUM_PINS-1:0] PIN_IN,
  input wire logic MON_STREAM_IN,
  output logic [NUM_PINS-1:0] PIN_OUT,
  output logic [NUM_PINS-1:0] PIN_OE_N_OUT,
  output logic [NUM_PINS-1:0] PIN_PULLUP_OUT,
  output logic CLKOUT_OUT,
  output logic CLKOUT_OE_N_OUT,
  output logic [2:0] CLKOUT_DRIVE_OUT,
  output logic OSC_LOW_POWER_OUT,
  output logic POWER_DOWN_OUT,
  output logic [1:0] CRYSTAL_FREQ_ID_OUT,
  output logic ANALOG_CODEC_SEL_OUT,
  output logic MIC_INPUT_SEL_OUT,
  output logic [1:0] SERIAL_MODE_OUT,
  output logic LINK_CHAIN_OUT,
  output logic LINK_BYPASS_OUT,
  output logic LINK_SLOT_OUT,
  output logic [1:0] LINK_DELAY_OUT,
  output logic PORT_ISOLATE_OUT,
  output logic [15:0] SAMPLE_RATE_OUT,
  output logic [15:0] LEVEL_CTRL_OUT
);

  localparam logic [NUM_PINS-1:0] ALL_ONES = {NUM_PINS{1'b1}};
  localparam logic [NUM_PINS-1:0] ALL_ZERO = {NUM_PINS{1'b0}};

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic arst_any_n, in_reset, release_evt, wr_en, bank_one, wake_flag, clk_enable, link_mode;
  logic rst_meta_r, rst_sync_r, rst_prev_r, clkout_run_r, captured_r;
  logic [15:0] cfg1_r, cfg2_r, clkctl_r, sample_rate_r, level_ctrl_r, rdata_nxt;
  logic [NUM_PINS-1:0] pin_meta_r, pin_sync_r, pin_data_r, init_state_r;
  logic [NUM_PINS-1:0] pin_dir_r, pin_pol_r, pin_sticky_r, pin_wake_en_r, pin_pullup_r, pin_od_r;
  logic [NUM_PINS-1:0] pin_status_r, pin_status_nxt, role_mask, in_mask, active_lvl;
  logic [NUM_PINS-1:0] wdata_pins, clr_mask;

  // ---------------------------------------------------------------------------
  // Reset pin synchroniser
  // ---------------------------------------------------------------------------
  // Either reset source forces the clock-out enable flop to its value
  assign arst_any_n = ARST_N_IN & POR_N_IN;

  // Reset pin level seen on the system clock; this logic must keep running
  // through device reset, so it only listens to power-on reset
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
      rst_prev_r <= 1'b0;
    end else begin
      rst_meta_r <= ARST_N_IN;
      rst_sync_r <= rst_meta_r;
      rst_prev_r <= rst_sync_r;
    end
  end

  assign in_reset = ~rst_sync_r;
  assign release_evt = rst_sync_r & ~rst_prev_r;

  // ---------------------------------------------------------------------------
  // Pin input synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      pin_meta_r <= ALL_ONES;
      pin_sync_r <= ALL_ONES;
    end else begin
      pin_meta_r <= PIN_IN;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // Writes are dropped while the device is held in reset
  assign wr_en = REG_WR_IN & ~in_reset;
  assign bank_one = (cfg1_r[CFG1_BANK_LSB +: 2] == BANK_ONE); // RULE_21
  assign wdata_pins = REG_WDATA_IN[NUM_PINS-1:0];

  // ---------------------------------------------------------------------------
  // Configuration register one
  // ---------------------------------------------------------------------------
  // Survives device reset; bank, power mode, crystal id and codec select
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      cfg1_r <= CFG1_RST;
    end else if (wr_en && REG_ADDR_IN == OFS_CONFIG_ONE) begin
      cfg1_r <= REG_WDATA_IN & CFG1_MASK; // RULE_03 RULE_04
    end
  end

  // Run-time clock enable sits on the device reset so it comes back set
  always_ff @(posedge CLK_SYS_IN or negedge arst_any_n) begin
    if (!arst_any_n) begin
      clkout_run_r <= 1'b1; // RULE_05
    end else if (wr_en && REG_ADDR_IN == OFS_CONFIG_ONE) begin
      clkout_run_r <= REG_WDATA_IN[CFG1_CLKOUT_RUN];
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration register two
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      cfg2_r <= CFG2_RST;
    end else if (wr_en && REG_ADDR_IN == OFS_CONFIG_TWO) begin
      cfg2_r <= REG_WDATA_IN & CFG2_MASK;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock pin control (bank one only)
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      clkctl_r <= CLKCTL_RST; // RULE_09
    end else if (wr_en && bank_one && REG_ADDR_IN == OFS_CLK_PIN_CTRL) begin
      clkctl_r <= REG_WDATA_IN & CLKCTL_MASK; // RULE_07 RULE_08 RULE_21
    end
  end

  // ---------------------------------------------------------------------------
  // Sample rate and level control
  // ---------------------------------------------------------------------------
  // No interlock against a running codec: updates land immediately
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      sample_rate_r <= SAMPLE_RATE_RST;
      level_ctrl_r <= LEVEL_CTRL_RST;
    end else if (wr_en) begin
      if (REG_ADDR_IN == OFS_SAMPLE_RATE) begin
        sample_rate_r <= REG_WDATA_IN; // RULE_20
      end
      if (REG_ADDR_IN == OFS_LEVEL_CTRL) begin
        level_ctrl_r <= REG_WDATA_IN; // RULE_20
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pin control registers
  // ---------------------------------------------------------------------------
  // Power-on reset only, so a device reset leaves the pin setup alone
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      pin_dir_r <= ALL_ONES; // RULE_16
      pin_pullup_r <= ALL_ONES; // RULE_16
      pin_pol_r <= ALL_ONES;
      pin_sticky_r <= ALL_ZERO;
      pin_wake_en_r <= ALL_ZERO;
      pin_od_r <= ALL_ZERO;
    end else if (wr_en) begin
      unique case (REG_ADDR_IN)
        OFS_PIN_DIR: pin_dir_r <= wdata_pins; // RULE_17 RULE_18
        OFS_PIN_POLARITY: pin_pol_r <= wdata_pins; // RULE_17
        OFS_PIN_STICKY: pin_sticky_r <= wdata_pins; // RULE_17
        OFS_PIN_WAKE_EN: pin_wake_en_r <= wdata_pins;
        OFS_PIN_PULLUP: pin_pullup_r <= wdata_pins; // RULE_16
        OFS_PIN_OPEN_DRAIN: pin_od_r <= wdata_pins; // RULE_17
        default: ;
      endcase
    end
  end

  // Output data for pins set as outputs
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      pin_data_r <= ALL_ZERO;
    end else if (wr_en && REG_ADDR_IN == OFS_PIN_STATUS) begin
      pin_data_r <= wdata_pins;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin events
  // ---------------------------------------------------------------------------
  // Pins taken by an alternate role stop acting as plain inputs
  always_comb begin
    role_mask = ALL_ZERO;
    role_mask[PIN_WAKE] = cfg2_r[CFG2_WAKE_PIN];
    role_mask[PIN_MON] = cfg2_r[CFG2_MON_PIN];
    role_mask[PIN_MIC] = cfg2_r[CFG2_MIC_PIN]; // RULE_12
  end

  assign in_mask = pin_dir_r & ~role_mask;
  // Polarity bit 1 means the event is a high level
  assign active_lvl = ~(pin_sync_r ^ pin_pol_r) & in_mask; // RULE_17
  // Writing 0 to a sticky input bit clears it
  assign clr_mask = (wr_en && REG_ADDR_IN == OFS_PIN_STATUS) ? (~wdata_pins & in_mask) : ALL_ZERO;

  // Sticky bits hold until cleared; a new event in the clear cycle wins
  always_comb begin
    pin_status_nxt = (pin_status_r & ~clr_mask & pin_sticky_r & in_mask) | active_lvl; // RULE_17
  end

  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      pin_status_r <= ALL_ZERO;
    end else begin
      pin_status_r <= pin_status_nxt;
    end
  end

  // Qualifying event: any enabled input whose status is set
  assign wake_flag = |(pin_status_r & pin_wake_en_r);

  // ---------------------------------------------------------------------------
  // Initial pin state capture
  // ---------------------------------------------------------------------------
  // Taken once per power-up; later device resets do not overwrite it
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      captured_r <= 1'b0;
      init_state_r <= ALL_ZERO;
    end else if (release_evt && !captured_r) begin
      captured_r <= 1'b1; // RULE_14
      init_state_r <= pin_sync_r; // RULE_14
    end
  end

  // Mode straps: anything other than the DSP code counts as link mode
  assign link_mode = (init_state_r[PIN_MODE_LSB +: 2] != MODE_DSP); // RULE_15

  // ---------------------------------------------------------------------------
  // Clock output
  // ---------------------------------------------------------------------------
  // In reset the power mode bit has the last word over the in-reset enable
  assign clk_enable = in_reset ?
    (cfg1_r[CFG1_RESET_PWR_MODE] & cfg1_r[CFG1_CLKOUT_IN_RESET]) : // RULE_02 RULE_06
    clkout_run_r; // RULE_05

  // A flop cannot pass the clock itself, so the pad gets a half-rate copy;
  // stopping parks it low
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      CLKOUT_OUT <= 1'b0;
      CLKOUT_OE_N_OUT <= 1'b0;
      CLKOUT_DRIVE_OUT <= CLKCTL_RST[CLKCTL_DRIVE_LSB +: 3];
      POWER_DOWN_OUT <= 1'b0;
    end else begin
      CLKOUT_OUT <= clk_enable ? ~CLKOUT_OUT : 1'b0; // RULE_05
      CLKOUT_DRIVE_OUT <= clkctl_r[CLKCTL_DRIVE_LSB +: 3]; // RULE_08
      CLKOUT_OE_N_OUT <= (clkctl_r[CLKCTL_DRIVE_LSB +: 3] == DRIVE_OFF); // RULE_09
      POWER_DOWN_OUT <= in_reset & ~cfg1_r[CFG1_RESET_PWR_MODE]; // RULE_02
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  // Open-drain outputs drive only a low; the released level comes from the board
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      PIN_OUT <= ALL_ZERO;
      PIN_OE_N_OUT <= ALL_ONES;
      PIN_PULLUP_OUT <= ALL_ONES;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (i == PIN_WAKE && cfg2_r[CFG2_WAKE_PIN]) begin
          PIN_OUT[i] <= wake_flag; // RULE_10
          PIN_OE_N_OUT[i] <= 1'b0;
        end else if (i == PIN_MON && cfg2_r[CFG2_MON_PIN]) begin
          PIN_OUT[i] <= MON_STREAM_IN; // RULE_11
          PIN_OE_N_OUT[i] <= 1'b0;
        end else if (i == PIN_MIC && cfg2_r[CFG2_MIC_PIN]) begin
          PIN_OUT[i] <= 1'b0; // RULE_12
          PIN_OE_N_OUT[i] <= 1'b1;
        end else if (!pin_dir_r[i]) begin
          PIN_OUT[i] <= pin_od_r[i] ? 1'b0 : pin_data_r[i]; // RULE_17
          PIN_OE_N_OUT[i] <= pin_od_r[i] & pin_data_r[i]; // RULE_17
        end else begin
          PIN_OUT[i] <= 1'b0;
          PIN_OE_N_OUT[i] <= 1'b1;
        end
        PIN_PULLUP_OUT[i] <= pin_pullup_r[i] & pin_dir_r[i] & ~role_mask[i]; // RULE_16
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Mode and setting outputs
  // ---------------------------------------------------------------------------
  // Link settings stay quiet in DSP mode so they cannot disturb it
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      OSC_LOW_POWER_OUT <= 1'b0;
      CRYSTAL_FREQ_ID_OUT <= XTAL_ID_RST;
      ANALOG_CODEC_SEL_OUT <= 1'b0;
      MIC_INPUT_SEL_OUT <= 1'b0;
      SERIAL_MODE_OUT <= MODE_DSP;
      LINK_CHAIN_OUT <= 1'b0;
      LINK_BYPASS_OUT <= 1'b0;
      LINK_SLOT_OUT <= 1'b0;
      LINK_DELAY_OUT <= 2'h0;
      PORT_ISOLATE_OUT <= 1'b0;
      SAMPLE_RATE_OUT <= SAMPLE_RATE_RST;
      LEVEL_CTRL_OUT <= LEVEL_CTRL_RST;
    end else begin
      OSC_LOW_POWER_OUT <= clkctl_r[CLKCTL_OSC_LP]; // RULE_07
      CRYSTAL_FREQ_ID_OUT <= cfg1_r[CFG1_XTAL_LSB +: 2]; // RULE_03
      ANALOG_CODEC_SEL_OUT <= cfg1_r[CFG1_ANALOG_SEL]; // RULE_04
      MIC_INPUT_SEL_OUT <= cfg2_r[CFG2_MIC_PIN]; // RULE_12
      SERIAL_MODE_OUT <= init_state_r[PIN_MODE_LSB +: 2]; // RULE_15
      LINK_CHAIN_OUT <= cfg2_r[CFG2_LINK_CHAIN] & link_mode; // RULE_13
      LINK_BYPASS_OUT <= cfg2_r[CFG2_LINK_BYPASS] & link_mode; // RULE_13
      LINK_SLOT_OUT <= cfg2_r[CFG2_LINK_SLOT] & link_mode; // RULE_13
      LINK_DELAY_OUT <= cfg2_r[CFG2_LINK_DELAY_LSB +: 2] & {2{link_mode}}; // RULE_13
      PORT_ISOLATE_OUT <= cfg2_r[CFG2_PORT_ISOLATE];
      SAMPLE_RATE_OUT <= sample_rate_r;
      LEVEL_CTRL_OUT <= level_ctrl_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Unmapped offsets, and banked offsets outside bank one, read as zero
  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (REG_ADDR_IN)
      OFS_SAMPLE_RATE: rdata_nxt = sample_rate_r;
      OFS_LEVEL_CTRL: rdata_nxt = level_ctrl_r;
      OFS_PIN_DIR: rdata_nxt = 16'(pin_dir_r);
      OFS_PIN_POLARITY: rdata_nxt = 16'(pin_pol_r);
      OFS_PIN_STICKY: rdata_nxt = 16'(pin_sticky_r);
      OFS_PIN_WAKE_EN: rdata_nxt = 16'(pin_wake_en_r);
      OFS_PIN_STATUS: rdata_nxt = 16'(pin_status_r | (pin_data_r & ~pin_dir_r));
      OFS_PIN_PULLUP: rdata_nxt = 16'(pin_pullup_r);
      OFS_PIN_OPEN_DRAIN: rdata_nxt = 16'(pin_od_r);
      OFS_CONFIG_ONE: begin
        rdata_nxt = cfg1_r;
        rdata_nxt[CFG1_CLKOUT_RUN] = clkout_run_r;
      end
      OFS_CONFIG_TWO: rdata_nxt = cfg2_r;
      OFS_PIN_INIT_STATE: rdata_nxt = bank_one ? 16'(init_state_r) : 16'h0000; // RULE_21
      OFS_CLK_PIN_CTRL: rdata_nxt = bank_one ? clkctl_r : 16'h0000; // RULE_21
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      REG_RDATA_OUT <= 16'h0000;
    end else begin
      REG_RDATA_OUT <= REG_RD_IN ? rdata_nxt : 16'h0000;
    end
  end

endmodule : cic_top

`default_nettype wire

//--- dv/cic_top_chk.sv
// Port-level assertions for the codec configuration block
`timescale 1ns/1ps
`default_nettype none
module cic_top_chk
  import cic_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic POR_N_IN,
  input wire logic [6:0] REG_ADDR_IN,
  input wire logic REG_RD_IN,
  input wire logic [15:0] REG_RDATA_OUT,
  input wire logic CLKOUT_OUT,
  input wire logic CLKOUT_OE_N_OUT,
  input wire logic [2:0] CLKOUT_DRIVE_OUT,
  input wire logic OSC_LOW_POWER_OUT,
  input wire logic POWER_DOWN_OUT,
  input wire logic [1:0] CRYSTAL_FREQ_ID_OUT,
  input wire logic ANALOG_CODEC_SEL_OUT,
  input wire logic [1:0] SERIAL_MODE_OUT,
  input wire logic LINK_CHAIN_OUT
);
  // One domain; only power-on reset clears what is watched here
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!POR_N_IN);
  property p_pad; CLKOUT_OE_N_OUT == (CLKOUT_DRIVE_OUT == DRIVE_OFF); endproperty
  a_pad: assert property (p_pad) else $error("pad enable wrong");
  property p_pwr; ARST_N_IN [*4] |-> !POWER_DOWN_OUT; endproperty
  a_pwr: assert property (p_pwr) else $error("power down out of reset");
  property p_held; POWER_DOWN_OUT [*3] |-> !CLKOUT_OUT; endproperty
  a_held: assert property (p_held) else $error("clock runs powered down");
  property p_run; $rose(ARST_N_IN) |-> ##[1:8] $changed(CLKOUT_OUT); endproperty
  a_run: assert property (p_run) else $error("clock not restarted");
  property p_ctl; REG_RD_IN && REG_ADDR_IN == OFS_CLK_PIN_CTRL |=> REG_RDATA_OUT == 16'h0
    || REG_RDATA_OUT[3:0] == {OSC_LOW_POWER_OUT, CLKOUT_DRIVE_OUT}; endproperty
  a_ctl: assert property (p_ctl) else $error("clock control outputs");
  property p_cfg; REG_RD_IN && REG_ADDR_IN == OFS_CONFIG_ONE |=>
    REG_RDATA_OUT[11:9] == {CRYSTAL_FREQ_ID_OUT, ANALOG_CODEC_SEL_OUT}; endproperty
  a_cfg: assert property (p_cfg) else $error("crystal or codec select");
  property p_link; SERIAL_MODE_OUT == MODE_DSP |-> !LINK_CHAIN_OUT; endproperty
  a_link: assert property (p_link) else $error("link setting in dsp mode");
  property p_mode; ARST_N_IN [*8] |-> $stable(SERIAL_MODE_OUT); endproperty
  a_mode: assert property (p_mode) else $error("mode changed");
endmodule : cic_top_chk
`default_nettype wire

//--- dv/cic_host_model.sv
// Register-bus host standing in for the serial link controller
`timescale 1ns/1ps
`default_nettype none
module cic_host_model (
  input wire logic clk_in,
  output logic [6:0] addr_out,
  output logic [15:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [15:0] rdata_in
);
  // Idle bus from time zero
  initial begin
    addr_out = 7'h0;
    wdata_out = 16'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One-cycle write strobe; a cycle gap keeps strobes from merging
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask : rd
endmodule : cic_host_model
`default_nettype wire

//--- dv/cic_top_bench.sv
// Self-checking bench of the codec configuration block
`timescale 1ns/1ps
`default_nettype none
module cic_top_bench
  import cic_pkg::*;
;
  logic CLK_SYS_IN, ARST_N_IN, POR_N_IN, REG_WR_IN, REG_RD_IN, MON_STREAM_IN;
  logic [6:0] REG_ADDR_IN;
  logic [15:0] REG_WDATA_IN, REG_RDATA_OUT, SAMPLE_RATE_OUT, LEVEL_CTRL_OUT, v;
  logic [7:0] ext, PIN_OUT, PIN_OE_N_OUT, PIN_PULLUP_OUT;
  wire [7:0] PIN_IN;
  logic CLKOUT_OUT, CLKOUT_OE_N_OUT, OSC_LOW_POWER_OUT, POWER_DOWN_OUT, ANALOG_CODEC_SEL_OUT;
  logic MIC_INPUT_SEL_OUT, LINK_CHAIN_OUT, LINK_BYPASS_OUT, LINK_SLOT_OUT, PORT_ISOLATE_OUT;
  logic [2:0] CLKOUT_DRIVE_OUT;
  logic [1:0] CRYSTAL_FREQ_ID_OUT, SERIAL_MODE_OUT, LINK_DELAY_OUT;
  int failures = 0;
  int comparisons = 0;
  // Packed views of related outputs, so each compare stays on one line
  wire [15:0] link_w = {10'h0, LINK_CHAIN_OUT, LINK_BYPASS_OUT, LINK_SLOT_OUT, LINK_DELAY_OUT,
    PORT_ISOLATE_OUT};
  wire [15:0] pins_w = {9'h0, PIN_PULLUP_OUT[0], PIN_OE_N_OUT[0], PIN_OUT[4:0]};
  // Pin wire: the device wins where it drives, else the board level
  assign PIN_IN = (~PIN_OE_N_OUT & PIN_OUT) | (PIN_OE_N_OUT & ext);
  cic_top dut_u (.*);
  cic_host_model host_u (.clk_in(CLK_SYS_IN), .addr_out(REG_ADDR_IN), .wdata_out(REG_WDATA_IN),
    .wr_out(REG_WR_IN), .rd_out(REG_RD_IN), .rdata_in(REG_RDATA_OUT));
  // 100 MHz clock
  initial begin
    CLK_SYS_IN = 1'b0;
    forever #5 CLK_SYS_IN = ~CLK_SYS_IN;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rc(input logic [6:0] a, input logic [15:0] e);
    host_u.rd(a, v);
    chk($sformatf("reg %h", a), v, e);
  endtask : rc
  // Covers the reset synchroniser, capture and output lag
  task automatic st;
    repeat (5) @(posedge CLK_SYS_IN);
    #1;
  endtask : st
  task automatic toggles;
    logic b;
    b = CLKOUT_OUT;
    @(posedge CLK_SYS_IN);
    #1;
    chk("clk runs", {15'h0, CLKOUT_OUT}, {15'h0, ~b});
  endtask : toggles
  task automatic t_clock;
    rc(OFS_CONFIG_ONE, CFG1_RST | 16'h0080);
    rc(OFS_CLK_PIN_CTRL, 16'h0);
    rc(7'h7a, 16'h0);
    chk("pull", {PIN_OE_N_OUT, PIN_PULLUP_OUT}, 16'hffff);
    host_u.wr(OFS_CONFIG_ONE, 16'h2000);
    rc(OFS_CLK_PIN_CTRL, CLKCTL_RST);
    host_u.wr(OFS_PIN_INIT_STATE, 16'h0055);
    rc(OFS_PIN_INIT_STATE, 16'h002c);
    chk("mode", {14'h0, SERIAL_MODE_OUT}, 16'h3);
    host_u.wr(OFS_CLK_PIN_CTRL, 16'h000a);
    st;
    chk("clk", {11'h0, CLKOUT_OUT, OSC_LOW_POWER_OUT, CLKOUT_DRIVE_OUT}, 16'ha);
    host_u.wr(OFS_CLK_PIN_CTRL, 16'h0000);
    st;
    chk("pad", {15'h0, CLKOUT_OE_N_OUT}, 16'h1);
  endtask : t_clock
  task automatic t_cfg;
    host_u.wr(OFS_CONFIG_TWO, 16'h7fc0);
    host_u.wr(OFS_CONFIG_ONE, 16'h2a00);
    host_u.wr(OFS_SAMPLE_RATE, 16'h1f40);
    host_u.wr(OFS_LEVEL_CTRL, 16'h0c0c);
    st;
    rc(OFS_CONFIG_TWO, 16'h7fc0);
    chk("mic", {15'h0, MIC_INPUT_SEL_OUT}, 16'h1);
    chk("link", link_w, 16'h003f);
    chk("xtal", {13'h0, CRYSTAL_FREQ_ID_OUT, ANALOG_CODEC_SEL_OUT}, 16'h5);
    chk("rate", SAMPLE_RATE_OUT ^ LEVEL_CTRL_OUT, 16'h134c);
  endtask : t_cfg
  task automatic t_reset(input logic [15:0] c);
    host_u.wr(OFS_CONFIG_ONE, c);
    ARST_N_IN <= 1'b0;
    st;
    chk("pdn", {15'h0, POWER_DOWN_OUT}, {15'h0, ~c[12]});
    if (c[12]) toggles;
    host_u.wr(OFS_SAMPLE_RATE, 16'h0001);
    ARST_N_IN <= 1'b1;
    st;
    rc(OFS_CONFIG_ONE, c | 16'h0080);
    rc(OFS_SAMPLE_RATE, 16'h1f40);
    toggles;
  endtask : t_reset
  task automatic t_pins;
    host_u.wr(OFS_PIN_POLARITY, 16'h00db);
    host_u.wr(OFS_PIN_DIR, 16'h00fe);
    host_u.wr(OFS_PIN_STICKY, 16'h0020);
    host_u.wr(OFS_PIN_STATUS, 16'h0001);
    host_u.wr(OFS_PIN_WAKE_EN, 16'h0020);
    host_u.wr(OFS_PIN_PULLUP, 16'h00fe);
    MON_STREAM_IN <= 1'b1;
    ext[5] <= 1'b0;
    @(posedge CLK_SYS_IN);
    ext[5] <= 1'b1;
    st;
    chk("pins", pins_w, 16'h0019);
    rc(OFS_PIN_STATUS, 16'h0021);
    host_u.wr(OFS_PIN_STATUS, 16'h0001);
    host_u.wr(OFS_PIN_OPEN_DRAIN, 16'h0001);
    st;
    chk("clear", {14'h0, PIN_OUT[3], PIN_OE_N_OUT[0]}, 16'h1);
  endtask : t_pins
  task automatic t_dsp;
    POR_N_IN <= 1'b0;
    ARST_N_IN <= 1'b0;
    ext <= 8'h20;
    st;
    POR_N_IN <= 1'b1;
    ARST_N_IN <= 1'b1;
    st;
    chk("dsp", {14'h0, SERIAL_MODE_OUT}, {14'h0, MODE_DSP});
    rc(OFS_SAMPLE_RATE, SAMPLE_RATE_RST);
    host_u.wr(OFS_CONFIG_TWO, 16'h7fc0);
    st;
    chk("nolink", link_w, 16'h0001);
  endtask : t_dsp
  task automatic wrap_up;
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  // Main sequence; power-on and device reset held four cycles
  initial begin
    POR_N_IN = 1'b0;
    ARST_N_IN = 1'b0;
    ext = 8'h2c;
    MON_STREAM_IN = 1'b0;
    repeat (4) @(posedge CLK_SYS_IN);
    POR_N_IN <= 1'b1;
    ARST_N_IN <= 1'b1;
    st;
    t_clock;
    t_cfg;
    t_reset(16'h2a00);
    t_reset(16'h3a40);
    t_pins;
    t_dsp;
    wrap_up;
  end
  // Watchdog, far beyond the 140 or so cycles the run needs
  initial begin
    #50000;
    failures++;
    wrap_up;
  end
endmodule : cic_top_bench
bind cic_top cic_top_chk chk_u (.*);
`default_nettype wire
